// File: gfs_function_select.v
// function selector for pins 4 to 7 with its control register
`timescale 1ns/1ps
`default_nettype none
`include "gfs_consts.vh"
module gfs_function_select
(
  // clock and synchronous register reset
  input wire i_clk,
  input wire i_sys_rst,
  // control interface register port
  input wire i_wr_en,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  // pin direction, bit n-4 for pin n, high = output
  input wire [3:0] i_pin_is_output,
  input wire [3:0] i_pin_in,
  input wire [3:0] i_gpio_out,
  // internal output sources
  input wire i_proc_clk_1mhz,
  input wire i_proc_clk,
  input wire i_supply_fault_n,
  input wire i_battery_fault_out,
  input wire i_mic_detect_out,
  input wire i_mic_short_out,
  input wire i_ada,
  input wire i_locked_loop_clock_out,
  input wire i_memory_reset_out,
  input wire i_rtc,
  input wire i_adc_frame_clock,
  input wire i_clk_32khz,
  input wire i_codec_output_clock,
  input wire i_flash_out,
  // pin drive
  output wire [3:0] o_pin_out,
  output wire [3:0] o_pin_alt,
  // internal input functions
  output wire o_power_state_input_one,
  output wire o_power_state_input_two,
  output wire o_power_state_input_three,
  output wire o_mask,
  output wire o_hibernate_level,
  output wire o_hibernate_edge,
  output wire o_flash_trigger,
  output wire o_adc_frame_clock_in,
  output wire o_power_off_input,
  output wire o_manual_reset_input,
  output wire o_chip_reset
);
  reg [15:0] sel;
  wire [3:0] pin7_function_code = sel[`GFS_PIN7_LSB +: 4];
  wire [3:0] pin6_function_code = sel[`GFS_PIN6_LSB +: 4];
  wire [3:0] pin5_function_code = sel[`GFS_PIN5_LSB +: 4];
  wire [3:0] pin4_function_code = sel[`GFS_PIN4_LSB +: 4];
  wire adc_frame_clock_inverted = ~i_adc_frame_clock;
  wire [3:0] alt_out;
  wire [3:0] alt_act;
  wire [3:0] next_pin_out;
  reg [3:0] pin_out;

  // one address decode shared by write and read paths
  function reg_hit;
    input [7:0] addr;
    begin
      reg_hit = addr == `GFS_REG_ADDR;
    end
  endfunction

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      sel <= `GFS_DEFAULT;
    else if (i_wr_en && reg_hit(i_addr))
      sel <= i_wdata;
  end

  // reads of other addresses give zero
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_rdata <= `GFS_RDATA_RST;
    else
      o_rdata <= reg_hit(i_addr) ? sel : 16'h0000;
  end

  // input functions, only when pin is an input
  function sel_in;
    input [3:0] code;
    input [3:0] want;
    input is_out;
    begin
      sel_in = !is_out && code == want;
    end
  endfunction

  wire [3:0] dir = i_pin_is_output;
  wire [3:0] p = i_pin_in;
  assign o_power_state_input_three = sel_in(pin7_function_code,
    `GFS_C1, dir[3]) & p[3];
  assign o_power_state_input_two = sel_in(pin6_function_code,
    `GFS_C1, dir[2]) & p[2];
  assign o_power_state_input_one = sel_in(pin5_function_code,
    `GFS_C1, dir[1]) & p[1];
  assign o_adc_frame_clock_in = sel_in(pin5_function_code,
    `GFS_C2, dir[1]) & p[1];
  assign o_power_off_input = sel_in(pin5_function_code,
    `GFS_C4, dir[1]) & p[1];
  assign o_manual_reset_input = sel_in(pin4_function_code,
    `GFS_C1, dir[0]) & p[0];
  assign o_chip_reset = sel_in(pin4_function_code,
    `GFS_C5, dir[0]) & p[0];
  // shared functions: any selecting pin asserts them
  assign o_mask = (sel_in(pin7_function_code, `GFS_C2, dir[3]) & p[3])
    | (sel_in(pin4_function_code, `GFS_C4, dir[0]) & p[0]);
  assign o_flash_trigger =
    (sel_in(pin6_function_code, `GFS_C2, dir[2]) & p[2])
    | (sel_in(pin4_function_code, `GFS_C2, dir[0]) & p[0]);
  assign o_hibernate_edge =
    (sel_in(pin6_function_code, `GFS_C3, dir[2]) & p[2])
    | (sel_in(pin5_function_code, `GFS_C3, dir[1]) & p[1]);
  assign o_hibernate_level =
    (sel_in(pin7_function_code, `GFS_C3, dir[3]) & p[3])
    | (sel_in(pin6_function_code, `GFS_C4, dir[2]) & p[2])
    | (sel_in(pin5_function_code, `GFS_C5, dir[1]) & p[1])
    | (sel_in(pin4_function_code, `GFS_C3, dir[0]) & p[0]);

  // output tables; unused slots carry code 0 which never matches
  wire [31:0] codes7 = {
    `GFS_C1,
    `GFS_C2,
    `GFS_C3,
    `GFS_C4,
    `GFS_C5,
    `GFS_C6,
    `GFS_CC,
    `GFS_CODE_GPIO
  };
  wire [7:0] vals7 = {
    i_proc_clk_1mhz,
    i_supply_fault_n,
    i_battery_fault_out,
    i_mic_detect_out,
    i_mic_short_out,
    i_ada,
    i_locked_loop_clock_out,
    1'b0
  };
  wire [31:0] codes6 = {
    `GFS_C1,
    `GFS_C2,
    `GFS_C3,
    `GFS_C4,
    `GFS_C5,
    `GFS_C6,
    `GFS_CODE_GPIO,
    `GFS_CODE_GPIO
  };
  wire [7:0] vals6 = {
    i_memory_reset_out,
    i_ada,
    i_rtc,
    i_mic_detect_out,
    i_mic_short_out,
    adc_frame_clock_inverted,
    2'b00
  };
  wire [31:0] codes5 = {
    `GFS_C1,
    `GFS_C2,
    `GFS_C3,
    `GFS_C4,
    `GFS_C5,
    `GFS_C6,
    `GFS_C7,
    `GFS_CA
  };
  wire [7:0] vals5 = {
    i_proc_clk,
    i_adc_frame_clock,
    i_clk_32khz,
    i_battery_fault_out,
    i_mic_short_out,
    i_ada,
    i_codec_output_clock,
    i_mic_detect_out
  };
  wire [31:0] codes4 = {
    `GFS_C1,
    `GFS_C2,
    `GFS_C3,
    `GFS_C4,
    `GFS_C5,
    `GFS_CA,
    `GFS_CODE_GPIO,
    `GFS_CODE_GPIO
  };
  wire [7:0] vals4 = {
    i_memory_reset_out,
    i_ada,
    i_flash_out,
    i_supply_fault_n,
    i_mic_short_out,
    i_mic_detect_out,
    2'b00
  };

  wire [127:0] all_codes = {codes7, codes6, codes5, codes4};
  wire [31:0] all_vals = {vals7, vals6, vals5, vals4};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pin
      gfs_code_map u_map
      (
        .i_code(sel[g*4 +: 4]),
        .i_is_output(dir[g]),
        .i_src_codes(all_codes[g*32 +: 32]),
        .i_src_val(all_vals[g*8 +: 8]),
        .o_alt_out(alt_out[g]),
        .o_alt_active(alt_act[g])
      );
      // unlisted codes fall back to plain gpio drive
      assign next_pin_out[g] = alt_act[g] ? alt_out[g] : i_gpio_out[g];
    end
  endgenerate

  // registered drive; costs a cycle of latency on routed clocks
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      pin_out <= `GFS_PIN_RST;
    else
      pin_out <= next_pin_out;
  end

  assign o_pin_out = pin_out;
  assign o_pin_alt = alt_act;
endmodule
`default_nettype wire

// File: gfs_consts.vh
// constants for the pin 4..7 function selector
`ifndef GFS_CONSTS_VH
`define GFS_CONSTS_VH
`define GFS_REG_ADDR 8'h8D
`define GFS_PIN7_LSB 12
`define GFS_PIN6_LSB 8
`define GFS_PIN5_LSB 4
`define GFS_PIN4_LSB 0
`define GFS_CODE_GPIO 4'h0
`define GFS_DEFAULT 16'h0000
`define GFS_RDATA_RST 16'h0000
`define GFS_PIN_RST 4'h0
`define GFS_C1 4'h1
`define GFS_C2 4'h2
`define GFS_C3 4'h3
`define GFS_C4 4'h4
`define GFS_C5 4'h5
`define GFS_C6 4'h6
`define GFS_C7 4'h7
`define GFS_CA 4'hA
`define GFS_CC 4'hC
`endif

// File: gfs_code_map.v
// per-pin decoder: one code against up to eight output sources
`timescale 1ns/1ps
`default_nettype none
module gfs_code_map
(
  // selection
  input wire [3:0] i_code,
  input wire i_is_output,
  // source codes packed eight by four bits, values one bit per slot
  input wire [31:0] i_src_codes,
  input wire [7:0] i_src_val,
  // result
  output reg o_alt_out,
  output reg o_alt_active
);
  integer k;
  always @*
  begin
    o_alt_out = 1'b0;
    o_alt_active = 1'b0;
    if (i_is_output && i_code != `GFS_CODE_GPIO)
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        if (i_src_codes[k*4 +: 4] == i_code)
        begin
          o_alt_out = i_src_val[k];
          o_alt_active = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: gfs_function_select_asserts.sv
// assertions for the pin 4..7 function selector
`timescale 1ns/1ps
`default_nettype none
module gfs_asserts
(
  // clock and register port
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  // pins and one source
  input wire logic [3:0] i_pin_is_output,
  input wire logic [3:0] i_pin_in,
  input wire logic [3:0] i_gpio_out,
  input wire logic i_locked_loop_clock_out,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_alt,
  // input functions
  input wire logic o_flash_trigger,
  input wire logic o_power_off_input,
  input wire logic o_chip_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [15:0] sel;
  sequence s_wr;
    i_wr_en && i_addr == 8'h8D;
  endsequence
  sequence s_rd;
    !i_wr_en && i_addr == 8'h8D;
  endsequence
  // shadow copy, so decodes can be judged without a read
  always_ff @(posedge i_clk)
    if (i_sys_rst)
      sel <= 16'h0000;
    else if (i_wr_en && i_addr == 8'h8D)
      sel <= i_wdata;
  AST_READBACK: assert property (s_wr ##1 s_rd |=> o_rdata == $past(i_wdata, 2))
    else $error("readback differs from write");
  AST_RST: assert property (disable iff (1'b0) i_sys_rst |=> !o_pin_out)
    else $error("pin drive not cleared by reset");
  AST_RST_REG: assert property (disable iff (1'b0) i_sys_rst |=>
    o_rdata == 16'h0000) else $error("read data not cleared by reset");
  AST_PIN7: assert property (sel[15:12] == 4'hC && i_pin_is_output[3] |->
    o_pin_alt[3] ##1 o_pin_out[3] == $past(i_locked_loop_clock_out))
    else $error("pin7 loop clock not routed");
  AST_PIN6: assert property (sel[11:8] == 4'h2 && !i_pin_is_output[2] |->
    o_flash_trigger == (i_pin_in[2] ||
    (sel[3:0] == 4'h2 && !i_pin_is_output[0] && i_pin_in[0])))
    else $error("pin6 flash input wrong");
  AST_PIN5: assert property (sel[7:4] == 4'h4 && !i_pin_is_output[1] |->
    o_power_off_input == i_pin_in[1]) else $error("pin5 power-off wrong");
  AST_PIN4: assert property (sel[3:0] == 4'h5 && !i_pin_is_output[0] |->
    o_chip_reset == i_pin_in[0]) else $error("pin4 chip reset wrong");
  AST_UNLISTED: assert property (sel[3:0] == 4'h7 && i_pin_is_output[0] |->
    !o_pin_alt[0] ##1 o_pin_out[0] == $past(i_gpio_out[0]))
    else $error("unlisted code not plain gpio");
endmodule
bind gfs_function_select gfs_asserts gfs_asserts_inst
(
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_wr_en(i_wr_en),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_pin_is_output(i_pin_is_output),
  .i_pin_in(i_pin_in),
  .i_gpio_out(i_gpio_out),
  .i_locked_loop_clock_out(i_locked_loop_clock_out),
  .o_pin_out(o_pin_out),
  .o_pin_alt(o_pin_alt),
  .o_flash_trigger(o_flash_trigger),
  .o_power_off_input(o_power_off_input),
  .o_chip_reset(o_chip_reset)
);
`default_nettype wire

// File: gfs_function_select_bench.sv
// self-checking bench for the pin 4..7 function selector
`timescale 1ns/1ps
`default_nettype none
module gfs_function_select_bench;
  logic i_clk = 0, i_sys_rst = 1, i_wr_en = 0;
  logic [13:0] srcs = 14'h3FFF;
  logic [7:0] i_addr = 8'h8D;
  logic [15:0] i_wdata = 16'h0000, w;
  logic [3:0] i_pin_is_output = 0, i_pin_in = 4'hF, i_gpio_out = 0, d, a, po;
  logic [10:0] f;
  wire i_proc_clk_1mhz = srcs[0], i_proc_clk = srcs[1];
  wire i_supply_fault_n = srcs[2], i_battery_fault_out = srcs[3];
  wire i_mic_detect_out = srcs[4], i_rtc = srcs[5];
  wire i_mic_short_out = srcs[6], i_ada = srcs[7];
  wire i_locked_loop_clock_out = srcs[8], i_memory_reset_out = srcs[9];
  wire i_adc_frame_clock = srcs[10], i_clk_32khz = srcs[11];
  wire i_codec_output_clock = srcs[12], i_flash_out = srcs[13];
  wire [15:0] o_rdata;
  wire [3:0] o_pin_out, o_pin_alt;
  wire o_power_state_input_one, o_power_state_input_two, o_mask;
  wire o_power_state_input_three, o_hibernate_level, o_hibernate_edge;
  wire o_flash_trigger, o_adc_frame_clock_in, o_power_off_input;
  wire o_manual_reset_input, o_chip_reset;
  wire [10:0] fin = {o_power_state_input_one, o_power_state_input_two,
    o_power_state_input_three, o_mask, o_hibernate_level, o_hibernate_edge,
    o_flash_trigger, o_adc_frame_clock_in, o_power_off_input,
    o_manual_reset_input, o_chip_reset};
  int num_errors = 0, tests_run = 0, cyc = 0;
  // code word, direction, alt select, pin drive, input functions
  // the inverted frame clock drives low while its source is high
  logic [38:0] rows [14] = '{
    {16'h1111, 4'hF, 4'hF, 4'hF, 11'h000},
    {16'h2222, 4'hF, 4'hF, 4'hF, 11'h000},
    {16'h3333, 4'hF, 4'hF, 4'hF, 11'h000},
    {16'h4444, 4'hF, 4'hF, 4'hF, 11'h000},
    {16'h5555, 4'hF, 4'hF, 4'hF, 11'h000},
    {16'h6666, 4'hF, 4'hE, 4'hA, 11'h000},
    {16'hC6A7, 4'hF, 4'hE, 4'hA, 11'h000},
    {16'h7775, 4'hF, 4'h3, 4'h3, 11'h000},
    {16'h1111, 4'h5, 4'h5, 4'h5, 11'h500},
    {16'h1111, 4'h0, 4'h0, 4'h0, 11'h702},
    {16'h2325, 4'h0, 4'h0, 4'h0, 11'h0A9},
    {16'h3443, 4'h0, 4'h0, 4'h0, 11'h044},
    {16'h0234, 4'h0, 4'h0, 4'h0, 11'h0B0},
    {16'h0050, 4'h0, 4'h0, 4'h0, 11'h040}};
  gfs_function_select gfs_function_select_inst (.*);
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (++cyc == 400)
    begin
      num_errors++;
      summarize();
    end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] v);
    @(negedge i_clk);
    i_wr_en = 1;
    i_addr = ad;
    i_wdata = v;
    @(negedge i_clk);
    i_wr_en = 0;
  endtask
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge i_clk);
    i_sys_rst = 0;
    chk(o_pin_out, 0);
    foreach (rows[k])
    begin
      {w, d, a, po, f} = rows[k];
      i_pin_is_output = d;
      wr(8'h8D, w);
      @(negedge i_clk);
      chk(o_rdata, w);
      chk(o_pin_alt, a);
      chk(o_pin_out, po);
      chk(fin, f);
    end
    // a write elsewhere must not land, and its read gives zero
    wr(8'h8C, 16'hFFFF);
    chk(o_rdata, 0);
    i_addr = 8'h8D;
    @(negedge i_clk);
    chk(o_rdata, 16'h0050);
    // raw pin level passes; shared functions merge both pins
    wr(8'h8D, 16'h2325);
    i_pin_in = 4'h5;
    @(negedge i_clk);
    chk(fin, 11'h021);
    wr(8'h8D, 16'h0202);
    i_pin_in = 4'h1;
    @(negedge i_clk);
    chk(fin, 11'h010);
    // unlisted codes and code zero drive the plain gpio level
    i_pin_is_output = 4'hF;
    i_gpio_out = 4'hA;
    wr(8'h8D, 16'h7707);
    @(negedge i_clk);
    chk(o_pin_alt, 4'h0);
    chk(o_pin_out, 4'hA);
    i_gpio_out = 4'h5;
    @(negedge i_clk);
    chk(o_pin_out, 4'h5);
    i_gpio_out = 4'h0;
    // pin drive must follow its own source, not a neighbour
    wr(8'h8D, 16'h1111);
    srcs = 14'h3FFE;
    repeat (2) @(negedge i_clk);
    chk(o_pin_out, 4'h7);
    srcs = 14'h3FFD;
    @(negedge i_clk);
    chk(o_pin_out, 4'hD);
    srcs = 14'h0000;
    @(negedge i_clk);
    chk(o_pin_out, 0);
    i_sys_rst = 1;
    @(negedge i_clk);
    i_sys_rst = 0;
    @(negedge i_clk);
    chk(o_rdata, 0);
    chk(o_pin_alt, 0);
    chk(o_pin_out, 0);
    summarize();
  end
endmodule
`default_nettype wire
